// [hw/clsd_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "clsd_map.svh"

// Overview of operation
// - Register-offset address is base register plus offset register, both low registers.
// - Register-offset bits 0,0 word store; 0,1 byte store; 1,0 word load; 1,1 byte load.
// - Halfword format: halfword store, halfword load, signed byte, signed halfword.
// - Halfword store writes only the low sixteen data bits.
// - Halfword load zeroes destination bits 16 to 31.
// - Signed byte load copies bit 7 into bits 8 to 31.
// - Signed halfword load copies bit 15 into bits 16 to 31.
// - Immediate format: same four transfers, address base plus immediate.
// - Immediate offset spans five bits for bytes, seven bits for words.
// - Word immediate field is multiplied by four.
// - Halfword immediate field is doubled before the add.
// - Immediate halfword stores low sixteen bits or loads with zero fill.
// - Timing matches the full-width transfer: one memory access each.
module clsd_decode (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Instruction issue.
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   output logic instr_ready,
   output logic instr_illegal,
   // Register file read values for the decoded fields.
   output logic [2:0] base_register,
   output logic [2:0] offset_register,
   output logic [2:0] data_register,
   input wire logic [31:0] base_value,
   input wire logic [31:0] offset_value,
   input wire logic [31:0] data_value,
   // Memory access.
   output logic mem_req,
   output logic mem_write,
   output logic [1:0] mem_size,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_done,
   input wire logic [31:0] mem_rdata,
   // Register write back.
   output logic wb_valid,
   output logic [2:0] wb_reg,
   output logic [31:0] wb_data
);

   typedef enum logic [2:0] {
      fmt_none, fmt_reg, fmt_sext, fmt_imm, fmt_half
   } clsd_fmt_t;

   function automatic clsd_fmt_t clsd_format(input logic [15:0] i);
      // Both register-offset formats share the top four bits; bit 9 picks
      // the sign format and leaves bits 11 and 10 free for the transfer kind.
      if ({i[15:12], i[`CLSD_SIGN_BIT]} == `CLSD_F7_OP) begin
         clsd_format = fmt_reg;
      end else if ({i[15:12], i[`CLSD_SIGN_BIT]} == `CLSD_F8_OP) begin
         clsd_format = fmt_sext;
      end else if (i[15:13] == `CLSD_F9_OP) begin
         clsd_format = fmt_imm;
      end else if (i[15:12] == `CLSD_F10_OP) begin
         clsd_format = fmt_half;
      end else begin
         clsd_format = fmt_none;
      end
   endfunction

   // Stores carry only the low data lanes with zero above them, so the
   // memory side never sees stale upper bits on a narrow write.
   function automatic logic [31:0] clsd_store_lanes(
      input clsd_pkg::clsd_size_t size,
      input logic [31:0] data
   );
      case (size)
         clsd_pkg::clsd_size_byte: begin
            clsd_store_lanes = {24'h0, data[7:0]};
         end
         clsd_pkg::clsd_size_half: begin
            clsd_store_lanes = {16'h0, data[15:0]};
         end
         default: begin
            clsd_store_lanes = data;
         end
      endcase
   endfunction

   // Narrow loads keep the low lanes of the read word and fill the rest by
   // zero or by the top loaded bit, so the lanes that were not asked for
   // never reach the register file.
   function automatic logic [31:0] clsd_load_fill(
      input clsd_pkg::clsd_size_t size,
      input logic sign,
      input logic [31:0] rdata
   );
      case (size)
         clsd_pkg::clsd_size_byte: begin
            if (sign) begin
               clsd_load_fill = {{24{rdata[7]}}, rdata[7:0]};
            end else begin
               clsd_load_fill = {24'h0, rdata[7:0]};
            end
         end
         clsd_pkg::clsd_size_half: begin
            if (sign) begin
               clsd_load_fill = {{16{rdata[15]}}, rdata[15:0]};
            end else begin
               clsd_load_fill = {16'h0, rdata[15:0]};
            end
         end
         default: begin
            clsd_load_fill = rdata;
         end
      endcase
   endfunction

   clsd_pkg::clsd_regs_t q_r;
   clsd_pkg::clsd_regs_t q_nxt;
   clsd_fmt_t fmt;
   logic [4:0] off5;
   logic [31:0] imm;
   logic dir;
   logic bsel;

   always_comb begin
      fmt = clsd_format(instr);
      data_register = instr[`CLSD_RD_LSB +: 3];
      base_register = instr[`CLSD_RB_LSB +: 3];
      offset_register = instr[`CLSD_RO_LSB +: 3];
      off5 = instr[`CLSD_OFF5_LSB +: 5];
      dir = instr[`CLSD_DIR_BIT];
      bsel = instr[`CLSD_SIZE_BIT];
      imm = 32'h0000_0000;
      q_nxt = q_r;
      q_nxt.wb_valid = 1'b0;
      instr_ready = (q_r.state == clsd_pkg::clsd_st_idle);
      instr_illegal = instr_valid && (fmt == fmt_none);
      case (q_r.state)
         clsd_pkg::clsd_st_idle: begin
            if (instr_valid && fmt != fmt_none) begin
               q_nxt.state = clsd_pkg::clsd_st_wait;
               q_nxt.mem_req = 1'b1;
               q_nxt.dest = data_register;
               q_nxt.sign_ext = 1'b0;
               case (fmt)
                  fmt_reg: begin
                     q_nxt.mem_write = ~dir;
                     q_nxt.size = bsel ? clsd_pkg::clsd_size_byte
                                       : clsd_pkg::clsd_size_word;
                     q_nxt.addr = base_value + offset_value;
                  end
                  fmt_sext: begin
                     // Here the bit at 11 is S and the bit at 10 is H.
                     q_nxt.mem_write = ~dir & ~bsel;
                     q_nxt.sign_ext = dir;
                     q_nxt.size = (dir & ~bsel) ? clsd_pkg::clsd_size_byte
                                                : clsd_pkg::clsd_size_half;
                     q_nxt.addr = base_value + offset_value;
                  end
                  fmt_imm: begin
                     q_nxt.mem_write = ~instr[`CLSD_F9_DIR_BIT];
                     if (instr[`CLSD_F9_SIZE_BIT]) begin
                        q_nxt.size = clsd_pkg::clsd_size_byte;
                        imm = {27'h0, off5};
                     end else begin
                        q_nxt.size = clsd_pkg::clsd_size_word;
                        imm = {25'h0, off5, 2'h0};
                     end
                     q_nxt.addr = base_value + imm;
                  end
                  default: begin
                     q_nxt.mem_write = ~instr[`CLSD_F9_DIR_BIT];
                     q_nxt.size = clsd_pkg::clsd_size_half;
                     imm = {26'h0, off5, 1'b0};
                     q_nxt.addr = base_value + imm;
                  end
               endcase
               q_nxt.wdata = clsd_store_lanes(q_nxt.size, data_value);
            end
         end
         clsd_pkg::clsd_st_wait: begin
            if (mem_done) begin
               q_nxt.state = clsd_pkg::clsd_st_idle;
               q_nxt.mem_req = 1'b0;
               q_nxt.wb_valid = ~q_r.mem_write;
               q_nxt.wb_reg = q_r.dest;
               q_nxt.wb_data = clsd_load_fill(q_r.size, q_r.sign_ext,
                                              mem_rdata);
            end
         end
         default: begin
            q_nxt.state = clsd_pkg::clsd_st_idle;
            q_nxt.mem_req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         q_r <= '{state: clsd_pkg::clsd_st_idle, mem_req: 1'b0,
                  mem_write: 1'b0, size: clsd_pkg::clsd_size_word,
                  sign_ext: 1'b0, dest: 3'h0, addr: `CLSD_ADDR_RST,
                  wdata: `CLSD_DATA_RST, wb_valid: 1'b0, wb_reg: 3'h0,
                  wb_data: `CLSD_DATA_RST};
      end else begin
         q_r <= q_nxt;
      end
   end

   // The encoding of the size output follows the package enum.
   assign mem_req = q_r.mem_req;
   assign mem_write = q_r.mem_write;
   assign mem_size = q_r.size;
   assign mem_addr = q_r.addr;
   assign mem_wdata = q_r.wdata;
   assign wb_valid = q_r.wb_valid;
   assign wb_reg = q_r.wb_reg;
   assign wb_data = q_r.wb_data;

endmodule
`default_nettype wire

// [hw/clsd_map.svh]
`ifndef CLSD_MAP_SVH
`define CLSD_MAP_SVH

// Instruction field positions.
`define CLSD_RD_LSB 0
`define CLSD_RB_LSB 3
`define CLSD_RO_LSB 6
`define CLSD_OFF5_LSB 6
`define CLSD_SIZE_BIT 10
`define CLSD_DIR_BIT 11
`define CLSD_F9_DIR_BIT 11
`define CLSD_F9_SIZE_BIT 12
`define CLSD_SIGN_BIT 9

// Opcode prefixes, one per format.
`define CLSD_F7_OP 5'h0A
`define CLSD_F8_OP 5'h0B
`define CLSD_F9_OP 3'h3
`define CLSD_F10_OP 4'h8

// Reset values.
`define CLSD_ADDR_RST 32'h0000_0000
`define CLSD_DATA_RST 32'h0000_0000

`endif

// [hw/clsd_pkg.sv]
package clsd_pkg;

   typedef enum logic [1:0] {
      clsd_size_byte,
      clsd_size_half,
      clsd_size_word
   } clsd_size_t;

   typedef enum logic [1:0] {
      clsd_st_idle,
      clsd_st_wait
   } clsd_state_t;

   typedef struct packed {
      clsd_state_t state;
      logic mem_req;
      logic mem_write;
      clsd_size_t size;
      logic sign_ext;
      logic [2:0] dest;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wb_valid;
      logic [2:0] wb_reg;
      logic [31:0] wb_data;
   } clsd_regs_t;

endpackage

// [verification/clsd_decode_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module clsd_decode_assertions (
   // Watched ports.
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic instr_ready,
   input wire logic instr_illegal,
   input wire logic [31:0] base_value,
   input wire logic [31:0] offset_value,
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [1:0] mem_size,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_done,
   input wire logic wb_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_take; instr_valid && instr_ready; endsequence
   property p_busy; mem_req |-> !instr_ready; endproperty
   a_busy: assert property (p_busy) else $error("busy");
   property p_hold; mem_req && !mem_done |=> $stable(mem_addr); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_end; mem_req && mem_done |=> !mem_req; endproperty
   a_end: assert property (p_end) else $error("end");
   property p_wb; wb_valid |-> $past(mem_done && !mem_write); endproperty
   a_wb: assert property (p_wb) else $error("wb");
   property p_pulse; wb_valid |=> !wb_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_hs; mem_write && mem_size == 2'h1 |-> !mem_wdata[31:16];
   endproperty
   a_hs: assert property (p_hs) else $error("hs");
   property p_imm; s_take ##0 instr[15:13] == 3'h3 |=> mem_req; endproperty
   a_imm: assert property (p_imm) else $error("imm");
   property p_f7; s_take ##0 instr[15:9] == 7'h28 |=>
      mem_addr == $past(base_value + offset_value); endproperty
   a_f7: assert property (p_f7) else $error("f7");
   property p_bad; s_take ##0 instr_illegal |=> !mem_req; endproperty
   a_bad: assert property (p_bad) else $error("bad");
   property p_f7b;
      s_take ##0 instr[15:12] == 4'h5 && !instr[9] && instr[10] |=>
         mem_size == 2'h0;
   endproperty
   a_f7b: assert property (p_f7b) else $error("f7b");
   property p_f8;
      s_take ##0 instr[15:12] == 4'h5 && instr[9] |=> mem_size != 2'h2;
   endproperty
   a_f8: assert property (p_f8) else $error("f8");
endmodule
bind clsd_decode clsd_decode_assertions u_clsd_decode_assertions (.*);
`default_nettype wire

// [verification/clsd_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module clsd_mem_model (
   // Memory side of the decoder.
   input wire logic ref_clk,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_done = 1'b0,
   output logic [31:0] mem_rdata
);
   logic [3:0] cnt = 4'h0;
   // Data is inverted off the done cycle, so a late sample cannot match.
   assign mem_rdata = mem_done ? 32'h123480F6 : 32'hEDCB7F09;
   always @(posedge ref_clk) begin
      cnt <= mem_req && !mem_done ? cnt + 4'h1 : 4'h0;
      mem_done <= mem_req && !mem_done && cnt == {2'h0, mem_addr[1:0]};
   end
endmodule
`default_nettype wire

// [verification/compact_load_store_decode_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module compact_load_store_decode_test;
   logic ref_clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0;
   logic [15:0] instr = 16'h0;
   logic [31:0] base_value = 32'hFFC, offset_value = 32'h7, ea;
   logic [31:0] data_value = 32'hA5C3F18E, mem_addr, mem_wdata;
   logic [31:0] mem_rdata, wb_data;
   logic instr_ready, instr_illegal, mem_req, mem_write, mem_done, wb_valid;
   logic [1:0] mem_size;
   logic [2:0] base_register, offset_register, data_register, wb_reg;
   int mismatches = 0, compares = 0;
   initial forever #2.5 ref_clk = ~ref_clk;
   clsd_decode u_clsd_decode (.*);
   clsd_mem_model u_clsd_mem_model (.*);
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic x(logic [15:0] i, logic [2:0] ws, logic [31:0] e);
      instr = i;
      instr_valid = 1'b1;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      `CHK({mem_req, mem_write, mem_size, mem_addr}, {1'h1, ws, ea})
      if (ws[2]) `CHK(mem_wdata, e)
      `CHK({base_register, data_register}, {3'h5, 3'h3})
      for (int k = 0; k < 20 && instr_ready !== 1'b1; k++) @(negedge ref_clk);
      `CHK({instr_ready, wb_valid}, {1'h1, !ws[2]})
      if (instr_ready !== 1'b1) wrap_up();
      if (!ws[2]) `CHK({wb_reg, wb_data}, {3'h3, e})
   endtask
   task automatic t_reg;
      ea = 32'h1003;
      x(16'h51AB, 3'h6, data_value);
      x(16'h55AB, 3'h4, 32'h8E);
      x(16'h59AB, 3'h2, 32'h123480F6);
      x(16'h5DAB, 3'h0, 32'hF6);
      x(16'h53AB, 3'h5, 32'hF18E);
      x(16'h57AB, 3'h1, 32'h80F6);
      x(16'h5BAB, 3'h0, 32'hFFFFFFF6);
      x(16'h5FAB, 3'h1, 32'hFFFF80F6);
      `CHK(offset_register, 3'h6)
      $display("t_reg done");
   endtask
   task automatic t_imm;
      ea = 32'h1078;
      x(16'h67EB, 3'h6, data_value);
      x(16'h6FEB, 3'h2, 32'h123480F6);
      ea = 32'h101B;
      x(16'h77EB, 3'h4, 32'h8E);
      x(16'h7FEB, 3'h0, 32'hF6);
      ea = 32'h103A;
      x(16'h87EB, 3'h5, 32'hF18E);
      x(16'h8FEB, 3'h1, 32'h80F6);
      $display("t_imm done");
   endtask
   task automatic t_bad;
      instr = 16'h4BAB;
      instr_valid = 1'b1;
      @(negedge ref_clk);
      `CHK({instr_illegal, mem_req, instr_ready}, 3'h5)
      instr = 16'h9BAB;
      @(negedge ref_clk);
      `CHK({instr_illegal, mem_req, instr_ready}, 3'h5)
      instr_valid = 1'b0;
      @(negedge ref_clk);
      `CHK({instr_illegal, mem_req}, 2'h0)
      $display("t_bad done");
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      t_reg();
      t_imm();
      t_bad();
      wrap_up();
   end
endmodule
`default_nettype wire
